// >>> irq_pending_release_bit_params.svh
// Constants of the bank 3 pending-clear register block.
// Assumes inclusion by bare name from package and modules.
`ifndef IRQ_PENDING_RELEASE_BIT_PARAMS_SVH
`define IRQ_PENDING_RELEASE_BIT_PARAMS_SVH

// =====================================================================
// Register map
// =====================================================================
`define PEND_CLR_BANK3_OFFSET  12'h000
`define ADDR_WIDTH             12
`define DATA_WIDTH             32

// =====================================================================
// Field layout
// =====================================================================
`define HI_FIELD_LSB           5'h10
`define HI_FIELD_WIDTH         8
`define HI_FIRST_IRQ           8'h50
`define LO_FIELD_LSB           5'h0A
`define LO_FIELD_WIDTH         4
`define LO_FIRST_IRQ           8'h4A
`define ASSIGNED_MASK          32'h00FF3C00
`define LINE_COUNT             12

`endif

// >>> irq_pending_release_bit_pkg.sv
// Types shared by the bank 3 pending-clear block.
// Assumes the constants header is on the include path.
`include "irq_pending_release_bit_params.svh"

package irq_pending_release_bit_pkg;

    // =================================================================
    // Bus phase states
    // =================================================================
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ACCESS = 2'b10
    } bus_state_t;

    typedef logic [`LINE_COUNT-1:0] line_vec_t;

    typedef struct packed {
        bus_state_t                 state;
        logic [`DATA_WIDTH-1:0]     rdata;
    } slave_state_t;

endpackage : irq_pending_release_bit_pkg

// >>> pend_clear_gate.sv
// Per-interrupt clear gating: one clear pulse per line.
// Assumes active flags come from the controller's servicing logic.
`timescale 1ns/10ps
`include "irq_pending_release_bit_params.svh"

module pend_clear_gate #(
    parameter int LINES = `LINE_COUNT
) (
    input  wire logic [LINES-1:0] write_ones,
    input  wire logic             write_strobe,
    input  wire logic [LINES-1:0] irq_active,
    output logic      [LINES-1:0] clear_pulse
);

    // =================================================================
    // Gate generation
    // =================================================================
    genvar i;
    generate
        for (i = 0; i < LINES; i++)
        begin : g_line
            // Zero writes and serviced lines give no clear
            assign clear_pulse[i] = write_strobe & write_ones[i]
                                  & ~irq_active[i];
        end
    endgenerate

endmodule : pend_clear_gate

// >>> irq_clear_pending_bank3.sv
// APB slave for the bank 3 pending-clear register.
// Assumes pending and active levels come from the controller core.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "irq_pending_release_bit_params.svh"

module irq_clear_pending_bank3 (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`ADDR_WIDTH-1:0]  paddr,
    input  wire logic [`DATA_WIDTH-1:0]  pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [`DATA_WIDTH-1:0]  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [`LINE_COUNT-1:0]  irq_pending,
    input  wire logic [`LINE_COUNT-1:0]  irq_active,
    output logic      [`LINE_COUNT-1:0]  pending_release_bit
);

    // =================================================================
    // Address decode
    // =================================================================
    function automatic logic hit_reg(input logic [`ADDR_WIDTH-1:0] a);
        if (a == `PEND_CLR_BANK3_OFFSET)
            hit_reg = 1'b1;
        else
            hit_reg = 1'b0;
    endfunction : hit_reg

    // =================================================================
    // Field packing between register word and interrupt lines
    // =================================================================
    function automatic irq_pending_release_bit_pkg::line_vec_t unpack_word(
        input logic [`DATA_WIDTH-1:0] w);
        unpack_word = {w[`HI_FIELD_LSB +: `HI_FIELD_WIDTH],
                       w[`LO_FIELD_LSB +: `LO_FIELD_WIDTH]};
    endfunction : unpack_word

    function automatic logic [`DATA_WIDTH-1:0] pack_word(
        input irq_pending_release_bit_pkg::line_vec_t v);
        logic [`DATA_WIDTH-1:0] w;
        w = '0;
        w[`HI_FIELD_LSB +: `HI_FIELD_WIDTH] =
            v[`LINE_COUNT-1 -: `HI_FIELD_WIDTH];
        w[`LO_FIELD_LSB +: `LO_FIELD_WIDTH] = v[`LO_FIELD_WIDTH-1:0];
        pack_word = w;
    endfunction : pack_word

    // =================================================================
    // State
    // =================================================================
    irq_pending_release_bit_pkg::slave_state_t st_ff;
    irq_pending_release_bit_pkg::slave_state_t nxt_st;

    logic access_phase;
    logic wr_take;
    logic lane_ok;
    logic [`DATA_WIDTH-1:0] wr_masked;

    assign access_phase = psel & penable;
    assign lane_ok      = (pstrb[1] & pstrb[2]);
    // Unassigned bits are dropped, so stray ones there do nothing
    assign wr_masked    = pwdata & `ASSIGNED_MASK;
    assign wr_take      = access_phase & pwrite & hit_reg(paddr) & lane_ok;

    pend_clear_gate #(
        .LINES        (`LINE_COUNT)
    ) u_gate (
        .write_ones   (unpack_word(wr_masked)),
        .write_strobe (wr_take),
        .irq_active   (irq_active),
        .clear_pulse  (pending_release_bit)
    );

    // =================================================================
    // Bus sequencing and read data
    // =================================================================
    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff.state)
            irq_pending_release_bit_pkg::BUS_IDLE:
            begin
                if (psel & ~penable)
                begin
                    nxt_st.state = irq_pending_release_bit_pkg::BUS_ACCESS;
                    // Sample the live pending levels for the read
                    if (~pwrite & hit_reg(paddr))
                        nxt_st.rdata = pack_word(irq_pending);
                    else
                        nxt_st.rdata = '0;
                end
            end
            irq_pending_release_bit_pkg::BUS_ACCESS:
            begin
                nxt_st.state = irq_pending_release_bit_pkg::BUS_IDLE;
            end
            default:
            begin
                nxt_st.state = irq_pending_release_bit_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff.state <= irq_pending_release_bit_pkg::BUS_IDLE;
            st_ff.rdata <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign pready  = 1'b1;
    assign prdata  = st_ff.rdata;
    // Unmapped address, or a write without both pstrb[1] and pstrb[2] set, reports an error
    assign pslverr = access_phase & (~hit_reg(paddr)
                   | (pwrite & ~lane_ok));

endmodule : irq_clear_pending_bank3

// >>> irq_clear_pending_bank3_props.sv
// Checker on the bank 3 pending-clear block ports.
// Assumes a bind from the testbench top file.
`timescale 1ns/10ps
`include "irq_pending_release_bit_params.svh"
module irq_clear_pending_bank3_props (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`ADDR_WIDTH-1:0] paddr,
    input wire logic [`DATA_WIDTH-1:0] pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic [`DATA_WIDTH-1:0] prdata,
    input wire logic [11:0]            irq_pending,
    input wire logic [11:0]            irq_active,
    input wire logic [11:0]            pending_release_bit
);
    wire logic [11:0] wsel = {pwdata[23:16], pwdata[13:10]};
    wire logic        wr_hit = psel && penable && pwrite
        && paddr == 12'h000 && pstrb[1] && pstrb[2];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    clr_map_a:
    assert property (wr_hit |-> pending_release_bit == (wsel & ~irq_active))
        else $error("clear pulse pattern wrong");
    active_hold_a:
    assert property ((pending_release_bit & irq_active) == 12'h000)
        else $error("clear pulse on serviced line");
    zero_keep_a:
    assert property (psel |-> (pending_release_bit & ~wsel) == 12'h000)
        else $error("clear pulse on zero bit");
    idle_quiet_a:
    assert property (!wr_hit |-> pending_release_bit == 12'h000)
        else $error("clear pulse outside write");
    read_live_a:
    assert property (psel && !penable && !pwrite && paddr == 12'h000 |=>
        prdata == {8'h00, $past(irq_pending[11:4]), 2'b00,
        $past(irq_pending[3:0]), 10'h000}) else $error("read data wrong");
endmodule : irq_clear_pending_bank3_props

// >>> tb_irq_clear_pending_bank3.sv
// Self-checking bench for the bank 3 pending-clear block.
// Assumes the design, package and checker files compiled first.
`timescale 1ns/10ps
module tb_irq_clear_pending_bank3;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000, irq_pending = 12'h000;
    logic [11:0] irq_active = 12'h000;
    logic [11:0] pending_release_bit;
    logic [31:0] pwdata = 32'h0, prdata, r, rel, err;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr;
    int          failures = 0, comparisons = 0;
    irq_clear_pending_bank3 u_dut (.*);
    initial forever #20 pclk = ~pclk;
    // ==============================================================
    // Bus, check and verdict tasks
    // ==============================================================
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        // Answer is taken at the edge that sees pready high
        while (pready !== 1'b1)
            @(posedge pclk);
        rel = {20'h00000, pending_release_bit};
        r = prdata;
        err = {31'h00000000, pslverr};
        psel <= 0;
        penable <= 0;
    endtask : xfer
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task give_verdict;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        irq_pending <= 12'hA5C;
        xfer(0, 12'h000, 32'h0);
        chk(r, 32'h00A53000);
        chk(err, 32'h0);
        irq_pending <= 12'h5A3;
        xfer(0, 12'h000, 32'h0);
        chk(r, 32'h005A0C00);
        xfer(0, 12'h004, 32'h0);
        chk(r, 32'h0);
        chk(err, 32'h1);
        $display("read test done");
        irq_active <= 12'h0F0;
        xfer(1, 12'h000, 32'h00FF3C00);
        chk(rel, 32'h00000F0F);
        chk(err, 32'h0);
        irq_active <= 12'h000;
        xfer(1, 12'h000, 32'h00A50000);
        chk(rel, 32'h00000A50);
        xfer(1, 12'h000, 32'h00002400);
        chk(rel, 32'h00000009);
        pstrb <= 4'h4;
        xfer(1, 12'h000, 32'h00FF3C00);
        chk(rel, 32'h0);
        chk(err, 32'h1);
        pstrb <= 4'hF;
        $display("write test done");
        give_verdict();
    end
    initial
    begin
        repeat (2000) @(posedge pclk);
        failures++;
        give_verdict();
    end
endmodule : tb_irq_clear_pending_bank3
bind irq_clear_pending_bank3 irq_clear_pending_bank3_props u_props (.*);
